// >>> core/ddr3_cmd_pkg.sv
package ddr3_cmd_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  // widths set by density
  localparam int BA_W   = 3;
  localparam int ROW_W  = 15;
  localparam int COL_W  = 10;
  localparam int NBANK  = 8;
  localparam int MRS_W  = 2;
  localparam int CNT_W  = 4;

  // ************************************************************
  // address bit roles
  // ************************************************************
  localparam int AP_BIT  = 10;
  localparam int OTF_BIT = 12;
  localparam int ZQ_BIT  = 10;
  localparam int BL_LSB  = 0;

  // burst-length field of mode register zero
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [MRS_W-1:0] MR_ZERO = 2'h0;

  // {cs_n, ras_n, cas_n, we_n} pin patterns
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_WR  = 4'h4;
  localparam logic [3:0] PIN_RD  = 4'h5;
  localparam logic [3:0] PIN_ZQ  = 4'h6;
  localparam logic [3:0] PIN_NOP = 4'h7;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS   = 50;
  localparam int EXIT_NS  = 24;
  localparam int EXIT_RAW = (EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXIT_CYC = (EXIT_RAW < 1) ? 1 : EXIT_RAW;
  localparam int BL8_CYC  = 4;
  localparam int BC4_CYC  = 2;

  typedef enum logic [3:0] {
    cmd_none, cmd_mrs, cmd_ref, cmd_sre, cmd_srx, cmd_pre, cmd_prea,
    cmd_act, cmd_wr, cmd_rd, cmd_zqcl, cmd_zqcs, cmd_pde, cmd_pdx
  } cmd_e;

  typedef enum logic [1:0] {pw_active, pw_pd, pw_sr} pwr_e;

endpackage : ddr3_cmd_pkg

// >>> core/ddr3_bank_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_bank_tracker (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_act,
  input  wire logic                           i_pre,
  input  wire logic                           i_prea,
  input  wire logic [ddr3_cmd_pkg::BA_W-1:0]  i_bank,
  input  wire logic [ddr3_cmd_pkg::ROW_W-1:0] i_row,
  input  wire logic                           i_ap_done,
  input  wire logic [ddr3_cmd_pkg::BA_W-1:0]  i_ap_bank,
  output logic      [ddr3_cmd_pkg::NBANK-1:0] o_open,
  output logic      [ddr3_cmd_pkg::ROW_W-1:0] o_sel_row
);

  logic [ddr3_cmd_pkg::ROW_W-1:0] row_r [ddr3_cmd_pkg::NBANK];

  // ************************************************************
  // per-bank open row
  // ************************************************************
  for (genvar b = 0; b < ddr3_cmd_pkg::NBANK; b++)
  begin : g_bank
    logic hit;
    logic ap_hit;
    assign hit    = (i_bank == ddr3_cmd_pkg::BA_W'(b));
    assign ap_hit = i_ap_done && (i_ap_bank == ddr3_cmd_pkg::BA_W'(b));
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        o_open[b] <= 1'h0;
        row_r[b]  <= '0;
      end
      else if (i_rst)
        o_open[b] <= 1'h0;
      else if (i_act && hit)
      begin
        o_open[b] <= 1'h1;
        row_r[b]  <= i_row;
      end
      else if (i_prea || (i_pre && hit) || ap_hit)
        o_open[b] <= 1'h0;
    end
  end

  assign o_sel_row = row_r[i_bank];

endmodule : ddr3_bank_tracker
`default_nettype wire

// >>> core/ddr3_burst_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_burst_timer (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_start,
  input  wire logic                          i_chop,
  input  wire logic                          i_ap,
  input  wire logic [ddr3_cmd_pkg::BA_W-1:0] i_bank,
  output logic                               o_busy,
  output logic                               o_ap_done,
  output logic      [ddr3_cmd_pkg::BA_W-1:0] o_ap_bank
);

  logic [ddr3_cmd_pkg::CNT_W-1:0] cnt_r;
  logic                           ap_r;
  logic                           last;

  assign last = o_busy && (cnt_r == ddr3_cmd_pkg::CNT_W'(1));

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_r     <= '0;
      o_busy    <= 1'h0;
      ap_r      <= 1'h0;
      o_ap_bank <= '0;
      o_ap_done <= 1'h0;
    end
    else if (i_rst)
    begin
      cnt_r     <= '0;
      o_busy    <= 1'h0;
      ap_r      <= 1'h0;
      o_ap_done <= 1'h0;
    end
    else
    begin
      o_ap_done <= last && ap_r;
      if (i_start && (!o_busy || last))
      begin
        cnt_r     <= i_chop ? ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BC4_CYC)
                            : ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BL8_CYC);
        o_busy    <= 1'h1;
        ap_r      <= i_ap;
        o_ap_bank <= i_bank;
      end
      else if (o_busy)
      begin
        cnt_r  <= cnt_r - ddr3_cmd_pkg::CNT_W'(1);
        o_busy <= !last;
      end
    end
  end

endmodule : ddr3_burst_timer
`default_nettype wire

// >>> core/ddr3_command_cke_decoder.sv
// Behaviour
// - commands decoded from cs, ras, cas, we, cke at each rising edge.
// - active-low reset pin clears all state without the clock.
// - termination input never affects decoding or cke states.
// - bank commands act on the bank named by bank address.
// - mode register set picks one of four registers by bank address.
// - valid fields driven by controller; don't-care fields ignored here.
// - address field widths follow density and configuration.
// - self-refresh exit needs only cke high, no running command clock; here cke is only sampled on a rising i_mclk edge.
// - started bursts always complete; later commands cannot cut them.
// - fixed or on-the-fly burst length comes from mode register zero.
// - no-operation registers nothing and leaves running work alone.
// - deselect behaves exactly like no-operation.
// - no refresh happens while powered down.
// - first long calibration is initial, later ones operational.
// - cke action chosen from state, cke previous and present edge.
// - idle means banks closed, no burst, cke high, exits elapsed.
// - address bit 10 on read or write requests auto precharge.
// - on-the-fly mode uses address bit 12: low chop, high full.
// - activate opens the row until that bank is precharged.
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_cke_decoder (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_cke,
  input  wire logic                           i_cs_n,
  input  wire logic                           i_ras_n,
  input  wire logic                           i_cas_n,
  input  wire logic                           i_we_n,
  input  wire logic [ddr3_cmd_pkg::BA_W-1:0]  i_ba,
  input  wire logic [ddr3_cmd_pkg::ROW_W-1:0] i_addr,
  output logic      [3:0]                     o_cmd,
  output logic                                o_cmd_vld,
  output logic                                o_illegal,
  output logic      [ddr3_cmd_pkg::BA_W-1:0]  o_bank,
  output logic      [ddr3_cmd_pkg::ROW_W-1:0] o_row,
  output logic      [ddr3_cmd_pkg::COL_W-1:0] o_col,
  output logic                                o_auto_pre,
  output logic                                o_chop,
  output logic                                o_mr_wr,
  output logic      [ddr3_cmd_pkg::MRS_W-1:0] o_mr_sel,
  output logic      [ddr3_cmd_pkg::ROW_W-1:0] o_mr_data,
  output logic                                o_zq_init,
  output logic      [1:0]                     o_pwr_state,
  output logic                                o_active_pd,
  output logic                                o_idle,
  output logic      [ddr3_cmd_pkg::NBANK-1:0] o_bank_open,
  output logic                                o_burst_busy
);

  // ************************************************************
  // decode
  // ************************************************************
  ddr3_cmd_pkg::pwr_e   pwr_r;
  ddr3_cmd_pkg::cmd_e   cmd_nxt;
  logic                 illegal_nxt;
  logic                 cke_prev_r;
  logic [1:0]           mr0_bl_r;
  logic                 zq_done_r;
  logic [ddr3_cmd_pkg::CNT_W-1:0] exit_cnt_r;
  logic [3:0]           pins;
  logic                 nop_des;
  logic                 banks_idle;
  logic                 chop_nxt;
  logic                 rw_ok;
  logic                 ap_done;
  logic [ddr3_cmd_pkg::BA_W-1:0]  ap_bank;
  logic [ddr3_cmd_pkg::ROW_W-1:0] sel_row;

  // termination pin is not an input at all
  assign pins       = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign nop_des    = i_cs_n || (pins == ddr3_cmd_pkg::PIN_NOP);
  assign banks_idle = (o_bank_open == '0) && !o_burst_busy;
  // a new burst may only start once the current one has ended
  assign rw_ok      = !o_burst_busy;

  // burst length from mode register zero
  // address bit 12 picks chop on the fly
  always_comb
  begin
    chop_nxt = 1'h0;
    unique case (mr0_bl_r)
      ddr3_cmd_pkg::BL_FIX4: chop_nxt = 1'h1;
      ddr3_cmd_pkg::BL_OTF:  chop_nxt = !i_addr[ddr3_cmd_pkg::OTF_BIT];
      default:               chop_nxt = 1'h0;
    endcase
  end

  // state plus cke at n-1 and n
  always_comb
  begin
    cmd_nxt     = ddr3_cmd_pkg::cmd_none;
    illegal_nxt = 1'h0;
    unique case (pwr_r)
      ddr3_cmd_pkg::pw_active:
      begin
        if (cke_prev_r && i_cke && !i_cs_n)
        begin
          unique case (pins)
            ddr3_cmd_pkg::PIN_MRS: cmd_nxt = ddr3_cmd_pkg::cmd_mrs;
            ddr3_cmd_pkg::PIN_REF: cmd_nxt = ddr3_cmd_pkg::cmd_ref;
            ddr3_cmd_pkg::PIN_PRE:
              cmd_nxt = i_addr[ddr3_cmd_pkg::AP_BIT]
                        ? ddr3_cmd_pkg::cmd_prea : ddr3_cmd_pkg::cmd_pre;
            ddr3_cmd_pkg::PIN_ACT: cmd_nxt = ddr3_cmd_pkg::cmd_act;
            ddr3_cmd_pkg::PIN_WR:
            begin
              if (rw_ok)
                cmd_nxt = ddr3_cmd_pkg::cmd_wr;
              else
                illegal_nxt = 1'h1;
            end
            ddr3_cmd_pkg::PIN_RD:
            begin
              if (rw_ok)
                cmd_nxt = ddr3_cmd_pkg::cmd_rd;
              else
                illegal_nxt = 1'h1;
            end
            ddr3_cmd_pkg::PIN_ZQ:
              cmd_nxt = i_addr[ddr3_cmd_pkg::ZQ_BIT]
                        ? ddr3_cmd_pkg::cmd_zqcl : ddr3_cmd_pkg::cmd_zqcs;
            default: cmd_nxt = ddr3_cmd_pkg::cmd_none;
          endcase
        end
        else if (cke_prev_r && !i_cke)
        begin
          if (!i_cs_n && pins == ddr3_cmd_pkg::PIN_REF && banks_idle)
            cmd_nxt = ddr3_cmd_pkg::cmd_sre;
          else if (nop_des)
            cmd_nxt = ddr3_cmd_pkg::cmd_pde;
          else
            // only legal commands with a transition
            illegal_nxt = 1'h1;
        end
      end
      ddr3_cmd_pkg::pw_pd:
      begin
        // exit on rising cke with nop
        if (!cke_prev_r && i_cke)
        begin
          if (nop_des)
            cmd_nxt = ddr3_cmd_pkg::cmd_pdx;
          else
            illegal_nxt = 1'h1;
        end
      end
      ddr3_cmd_pkg::pw_sr:
      begin
        // exit needs nothing but cke high
        if (i_cke)
          cmd_nxt = ddr3_cmd_pkg::cmd_srx;
      end
      default: illegal_nxt = 1'h1;
    endcase
  end

  // ************************************************************
  // power state
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    // pin reset acts without the clock
    if (!i_reset_n)
    begin
      pwr_r       <= ddr3_cmd_pkg::pw_active;
      cke_prev_r  <= 1'h0;
      o_active_pd <= 1'h0;
    end
    else if (i_rst)
    begin
      pwr_r       <= ddr3_cmd_pkg::pw_active;
      cke_prev_r  <= 1'h0;
      o_active_pd <= 1'h0;
    end
    else
    begin
      cke_prev_r <= i_cke;
      unique case (cmd_nxt)
        ddr3_cmd_pkg::cmd_sre: pwr_r <= ddr3_cmd_pkg::pw_sr;
        ddr3_cmd_pkg::cmd_pde:
        begin
          pwr_r       <= ddr3_cmd_pkg::pw_pd;
          o_active_pd <= !banks_idle;
        end
        ddr3_cmd_pkg::cmd_pdx,
        ddr3_cmd_pkg::cmd_srx:
        begin
          pwr_r       <= ddr3_cmd_pkg::pw_active;
          o_active_pd <= 1'h0;
        end
        default: pwr_r <= pwr_r;
      endcase
    end
  end

  // ************************************************************
  // exit wait and idle
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      exit_cnt_r <= '0;
      o_idle     <= 1'h0;
    end
    else if (i_rst)
    begin
      exit_cnt_r <= '0;
      o_idle     <= 1'h0;
    end
    else
    begin
      if (cmd_nxt == ddr3_cmd_pkg::cmd_pdx ||
          cmd_nxt == ddr3_cmd_pkg::cmd_srx)
        exit_cnt_r <= ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::EXIT_CYC);
      else if (exit_cnt_r != '0)
        exit_cnt_r <= exit_cnt_r - ddr3_cmd_pkg::CNT_W'(1);
      // idle needs every condition at once
      o_idle <= banks_idle && i_cke && (exit_cnt_r == '0) &&
                (pwr_r == ddr3_cmd_pkg::pw_active);
    end
  end

  // ************************************************************
  // mode register and calibration
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mr0_bl_r  <= ddr3_cmd_pkg::BL_FIX8;
      zq_done_r <= 1'h0;
    end
    else if (i_rst)
    begin
      mr0_bl_r  <= ddr3_cmd_pkg::BL_FIX8;
      zq_done_r <= 1'h0;
    end
    else
    begin
      if (cmd_nxt == ddr3_cmd_pkg::cmd_mrs &&
          i_ba[ddr3_cmd_pkg::MRS_W-1:0] == ddr3_cmd_pkg::MR_ZERO)
        mr0_bl_r <= i_addr[ddr3_cmd_pkg::BL_LSB +: 2];
      // only the first long one is initial
      if (cmd_nxt == ddr3_cmd_pkg::cmd_zqcl)
        zq_done_r <= 1'h1;
    end
  end

  // ************************************************************
  // registered command outputs
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cmd      <= 4'h0;
      o_cmd_vld  <= 1'h0;
      o_illegal  <= 1'h0;
      o_bank     <= '0;
      o_row      <= '0;
      o_col      <= '0;
      o_auto_pre <= 1'h0;
      o_chop     <= 1'h0;
      o_mr_wr    <= 1'h0;
      o_mr_sel   <= '0;
      o_mr_data  <= '0;
      o_zq_init  <= 1'h0;
    end
    else if (i_rst)
    begin
      o_cmd_vld <= 1'h0;
      o_illegal <= 1'h0;
      o_mr_wr   <= 1'h0;
    end
    else
    begin
      o_cmd     <= cmd_nxt;
      o_cmd_vld <= (cmd_nxt != ddr3_cmd_pkg::cmd_none);
      o_illegal <= illegal_nxt;
      o_mr_wr   <= (cmd_nxt == ddr3_cmd_pkg::cmd_mrs);
      if (cmd_nxt != ddr3_cmd_pkg::cmd_none)
      begin
        o_bank     <= i_ba;
        o_auto_pre <= i_addr[ddr3_cmd_pkg::AP_BIT];
        o_chop     <= chop_nxt;
        o_col      <= i_addr[ddr3_cmd_pkg::COL_W-1:0];
        o_row      <= (cmd_nxt == ddr3_cmd_pkg::cmd_act) ? i_addr : sel_row;
        o_zq_init  <= (cmd_nxt == ddr3_cmd_pkg::cmd_zqcl) && !zq_done_r;
      end
      if (cmd_nxt == ddr3_cmd_pkg::cmd_mrs)
      begin
        o_mr_sel  <= i_ba[ddr3_cmd_pkg::MRS_W-1:0];
        o_mr_data <= i_addr;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_pwr_state <= 2'h0;
    else
      o_pwr_state <= pwr_r;
  end

  // ************************************************************
  // banks and bursts
  // ************************************************************
  ddr3_bank_tracker u_banks (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_reset_n (i_reset_n),
    .i_act     (cmd_nxt == ddr3_cmd_pkg::cmd_act),
    .i_pre     (cmd_nxt == ddr3_cmd_pkg::cmd_pre),
    .i_prea    (cmd_nxt == ddr3_cmd_pkg::cmd_prea),
    .i_bank    (i_ba),
    .i_row     (i_addr),
    .i_ap_done (ap_done),
    .i_ap_bank (ap_bank),
    .o_open    (o_bank_open),
    .o_sel_row (sel_row)
  );

  // auto precharge travels with the burst
  ddr3_burst_timer u_burst (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_reset_n (i_reset_n),
    .i_start   (cmd_nxt == ddr3_cmd_pkg::cmd_wr ||
                cmd_nxt == ddr3_cmd_pkg::cmd_rd),
    .i_chop    (chop_nxt),
    .i_ap      (i_addr[ddr3_cmd_pkg::AP_BIT]),
    .i_bank    (i_ba),
    .o_busy    (o_burst_busy),
    .o_ap_done (ap_done),
    .o_ap_bank (ap_bank)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst || !i_reset_n);

  chk_sr_entry: assert property (
    cmd_nxt == ddr3_cmd_pkg::cmd_sre |=> pwr_r == ddr3_cmd_pkg::pw_sr)
    else $error("self refresh not entered");

  chk_pd_hold: assert property (
    pwr_r == ddr3_cmd_pkg::pw_pd && !i_cke |=> pwr_r == ddr3_cmd_pkg::pw_pd)
    else $error("power-down left with cke low");

  chk_nop_quiet: assert property (
    pwr_r == ddr3_cmd_pkg::pw_active && cke_prev_r && i_cke && nop_des
    |=> !o_cmd_vld && !o_illegal)
    else $error("nop or deselect registered a command");

  chk_burst_full: assert property (
    $rose(o_burst_busy) && !$past(chop_nxt) |-> o_burst_busy [*4])
    else $error("full burst cut short");

  chk_burst_chop: assert property (
    $rose(o_burst_busy) && $past(chop_nxt) |-> o_burst_busy [*2] ##1
    (!o_burst_busy || $past(cmd_nxt == ddr3_cmd_pkg::cmd_wr ||
                            cmd_nxt == ddr3_cmd_pkg::cmd_rd)))
    else $error("chopped burst length wrong");

  chk_ap_close: assert property (
    ap_done |=> !o_bank_open[$past(ap_bank)])
    else $error("auto precharge left bank open");

  chk_act_open: assert property (
    cmd_nxt == ddr3_cmd_pkg::cmd_act |=> o_bank_open[$past(i_ba)])
    else $error("activate did not open bank");

  chk_zq_once: assert property (
    o_cmd_vld && o_cmd == ddr3_cmd_pkg::cmd_zqcl && $past(zq_done_r)
    |-> !o_zq_init)
    else $error("second long calibration marked initial");

  chk_idle_def: assert property (
    o_idle |-> $past(o_bank_open == '0 && !o_burst_busy && i_cke))
    else $error("idle with work pending");

  chk_mr_sel: assert property (
    o_mr_wr |-> o_mr_sel == $past(i_ba[ddr3_cmd_pkg::MRS_W-1:0]))
    else $error("mode register select wrong");

  chk_no_pd_ref: assert property (
    pwr_r != ddr3_cmd_pkg::pw_active |-> cmd_nxt != ddr3_cmd_pkg::cmd_ref)
    else $error("refresh while powered down");

  cov_sr_cycle: cover property (
    cmd_nxt == ddr3_cmd_pkg::cmd_sre ##[1:20] cmd_nxt == ddr3_cmd_pkg::cmd_srx);
  cov_pd_cycle: cover property (
    cmd_nxt == ddr3_cmd_pkg::cmd_pde ##[1:20] cmd_nxt == ddr3_cmd_pkg::cmd_pdx);
  cov_ap_burst: cover property (ap_done);
  cov_rw_refused: cover property (o_illegal && o_burst_busy);

endmodule : ddr3_command_cke_decoder
`default_nettype wire

// >>> tb/ddr3_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// controller model
// ****************
module ddr3_ctl_model (
  input  wire logic        i_mclk,
  output logic             o_reset_n,
  output logic             o_cke,
  output logic [3:0]       o_pins,
  output logic [2:0]       o_ba,
  output logic [14:0]      o_addr
);
  initial o_reset_n = 1'b1;
  initial o_cke = 1'b1;
  initial o_pins = ddr3_cmd_pkg::PIN_NOP;
  initial o_ba = 3'h0;
  initial o_addr = 15'h0000;
  // table codes only, every field at a defined level
  task automatic issue(input logic [3:0] p, input logic [2:0] b,
                       input logic [14:0] a, input logic k);
    o_pins = p;
    o_ba = b;
    o_addr = a;
    o_cke = k;
    @(negedge i_mclk);
  endtask : issue
  // cke kept at its level; unused fields flip, never stale
  task automatic rest(input int n);
    o_pins = ddr3_cmd_pkg::PIN_NOP;
    o_ba = ~o_ba;
    o_addr = ~o_addr;
    repeat (n) @(negedge i_mclk);
  endtask : rest
  task automatic set_reset(input logic v);
    o_reset_n = v;
  endtask : set_reset
endmodule : ddr3_ctl_model
`default_nettype wire

// >>> tb/test_ddr3_command_cke_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_ddr3_command_cke_decoder;
  // ****************
  // bench signals
  // ****************
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  wire logic   i_reset_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n;
  wire logic [2:0]  i_ba;
  wire logic [14:0] i_addr;
  wire logic [3:0]  pins;
  logic [3:0]  o_cmd;
  logic        o_cmd_vld, o_illegal, o_auto_pre, o_chop, o_mr_wr;
  logic        o_zq_init, o_active_pd, o_idle, o_burst_busy;
  logic [2:0]  o_bank;
  logic [14:0] o_row, o_mr_data;
  logic [9:0]  o_col;
  logic [1:0]  o_mr_sel, o_pwr_state;
  logic [7:0]  o_bank_open;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #25 i_mclk = ~i_mclk;

  ddr3_command_cke_decoder dut_u (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_reset_n    (i_reset_n),
    .i_cke        (i_cke),
    .i_cs_n       (i_cs_n),
    .i_ras_n      (i_ras_n),
    .i_cas_n      (i_cas_n),
    .i_we_n       (i_we_n),
    .i_ba         (i_ba),
    .i_addr       (i_addr),
    .o_cmd        (o_cmd),
    .o_cmd_vld    (o_cmd_vld),
    .o_illegal    (o_illegal),
    .o_bank       (o_bank),
    .o_row        (o_row),
    .o_col        (o_col),
    .o_auto_pre   (o_auto_pre),
    .o_chop       (o_chop),
    .o_mr_wr      (o_mr_wr),
    .o_mr_sel     (o_mr_sel),
    .o_mr_data    (o_mr_data),
    .o_zq_init    (o_zq_init),
    .o_pwr_state  (o_pwr_state),
    .o_active_pd  (o_active_pd),
    .o_idle       (o_idle),
    .o_bank_open  (o_bank_open),
    .o_burst_busy (o_burst_busy)
  );
  ddr3_ctl_model m (
    .i_mclk    (i_mclk),
    .o_reset_n (i_reset_n),
    .o_cke     (i_cke),
    .o_pins    (pins),
    .o_ba      (i_ba),
    .o_addr    (i_addr)
  );
  assign {i_cs_n, i_ras_n, i_cas_n, i_we_n} = pins;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ****************
  // scenarios
  // ****************
  task automatic t_burst;
    m.issue(ddr3_cmd_pkg::PIN_NOP, 3'h1, 15'h0000, 1'b1);
    chk(o_cmd_vld, 1'b0);
    m.issue(4'hf, 3'h5, 15'h7fff, 1'b1);
    chk(o_cmd_vld, 1'b0);
    m.issue(ddr3_cmd_pkg::PIN_ACT, 3'h2, 15'h1234, 1'b1);
    chk(o_cmd, ddr3_cmd_pkg::cmd_act);
    chk(o_bank, 3'h2);
    chk({o_bank_open, o_row}, {8'h04, 15'h1234});
    m.issue(ddr3_cmd_pkg::PIN_RD, 3'h2, 15'h0405, 1'b1);
    chk({o_auto_pre, o_burst_busy}, 2'h3);
    chk({o_row, o_col}, {15'h1234, 10'h005});
    // refused read must not restart the burst
    m.issue(ddr3_cmd_pkg::PIN_RD, 3'h2, 15'h0000, 1'b1);
    chk(o_illegal, 1'b1);
    m.rest(3);
    chk(o_burst_busy, 1'b0);
    m.rest(1);
    chk(o_bank_open, 8'h00);
    $display("burst test done");
  endtask : t_burst

  task automatic t_mode;
    m.issue(ddr3_cmd_pkg::PIN_MRS, 3'h0, 15'h0001, 1'b1);
    chk({o_mr_wr, o_mr_sel, o_mr_data}, {3'h4, 15'h0001});
    m.issue(ddr3_cmd_pkg::PIN_ACT, 3'h3, 15'h0042, 1'b1);
    m.issue(ddr3_cmd_pkg::PIN_WR, 3'h3, 15'h0000, 1'b1);
    chk({o_cmd, o_chop}, {ddr3_cmd_pkg::cmd_wr, 1'b1});
    m.rest(2);
    m.issue(ddr3_cmd_pkg::PIN_WR, 3'h3, 15'h1000, 1'b1);
    chk(o_chop, 1'b0);
    m.rest(4);
    m.issue(ddr3_cmd_pkg::PIN_MRS, 3'h1, 15'h0002, 1'b1);
    chk(o_mr_sel, 2'h1);
    // a write to register one must leave the burst mode alone
    m.issue(ddr3_cmd_pkg::PIN_WR, 3'h3, 15'h1000, 1'b1);
    chk(o_chop, 1'b0);
    m.rest(4);
    m.issue(ddr3_cmd_pkg::PIN_PRE, 3'h3, 15'h0000, 1'b1);
    chk(o_cmd, ddr3_cmd_pkg::cmd_pre);
    m.issue(ddr3_cmd_pkg::PIN_ACT, 3'h6, 15'h0077, 1'b1);
    chk(o_bank_open, 8'h40);
    m.issue(ddr3_cmd_pkg::PIN_PRE, 3'h0, 15'h0400, 1'b1);
    chk(o_cmd, ddr3_cmd_pkg::cmd_prea);
    m.rest(1);
    chk(o_bank_open, 8'h00);
    // fixed chop ignores address bit 12
    m.issue(ddr3_cmd_pkg::PIN_MRS, 3'h0, 15'h0002, 1'b1);
    m.issue(ddr3_cmd_pkg::PIN_ACT, 3'h2, 15'h0000, 1'b1);
    m.issue(ddr3_cmd_pkg::PIN_RD, 3'h2, 15'h1400, 1'b1);
    chk({o_chop, o_auto_pre}, 2'h3);
    m.rest(3);
    chk({o_burst_busy, o_bank_open}, 9'h000);
    $display("mode test done");
  endtask : t_mode

  task automatic t_zq;
    m.issue(ddr3_cmd_pkg::PIN_ZQ, 3'h0, 15'h0400, 1'b1);
    chk({o_cmd, o_zq_init}, {ddr3_cmd_pkg::cmd_zqcl, 1'b1});
    m.issue(ddr3_cmd_pkg::PIN_ZQ, 3'h7, 15'h7fff, 1'b1);
    chk({o_cmd, o_zq_init}, {ddr3_cmd_pkg::cmd_zqcl, 1'b0});
    m.issue(ddr3_cmd_pkg::PIN_ZQ, 3'h7, 15'h7bff, 1'b1);
    chk(o_cmd, ddr3_cmd_pkg::cmd_zqcs);
    $display("calibration test done");
  endtask : t_zq

  task automatic t_power;
    m.issue(ddr3_cmd_pkg::PIN_NOP, 3'h0, 15'h0000, 1'b0);
    chk(o_cmd, ddr3_cmd_pkg::cmd_pde);
    m.rest(1);
    chk({o_pwr_state, o_active_pd}, 3'h2);
    // pins must be ignored while cke stays low
    m.issue(ddr3_cmd_pkg::PIN_ACT, 3'h4, 15'h0000, 1'b0);
    chk(o_cmd_vld, 1'b0);
    m.issue(ddr3_cmd_pkg::PIN_NOP, 3'h0, 15'h0000, 1'b1);
    chk(o_cmd, ddr3_cmd_pkg::cmd_pdx);
    m.rest(1);
    chk(o_idle, 1'b0);
    m.rest(2);
    chk({o_pwr_state, o_idle}, 3'h1);
    m.issue(ddr3_cmd_pkg::PIN_REF, 3'h0, 15'h0000, 1'b0);
    chk(o_cmd, ddr3_cmd_pkg::cmd_sre);
    m.rest(1);
    chk(o_pwr_state, 2'h2);
    m.issue(4'hf, 3'h0, 15'h0000, 1'b1);
    chk(o_cmd, ddr3_cmd_pkg::cmd_srx);
    m.rest(3);
    $display("power test done");
  endtask : t_power

  task automatic t_pin_reset;
    m.issue(ddr3_cmd_pkg::PIN_ACT, 3'h1, 15'h0010, 1'b1);
    // cke falls with a bank open: active power-down
    m.issue(ddr3_cmd_pkg::PIN_NOP, 3'h1, 15'h0000, 1'b0);
    chk({o_cmd, o_active_pd}, {ddr3_cmd_pkg::cmd_pde, 1'b1});
    m.set_reset(1'b0);
    // checked before the next rising edge: clearing must not wait
    #5;
    chk({o_bank_open, o_active_pd, o_pwr_state}, 11'h000);
    @(negedge i_mclk);
    m.set_reset(1'b1);
    m.issue(ddr3_cmd_pkg::PIN_NOP, 3'h0, 15'h0000, 1'b1);
    m.issue(ddr3_cmd_pkg::PIN_ZQ, 3'h0, 15'h0400, 1'b1);
    chk({o_cmd, o_zq_init}, {ddr3_cmd_pkg::cmd_zqcl, 1'b1});
    $display("pin reset test done");
  endtask : t_pin_reset

  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(negedge i_mclk);
    i_rst = 1'b0;
    m.rest(2);
    chk({o_pwr_state, o_bank_open}, 10'h000);
    t_burst();
    t_mode();
    t_zq();
    t_power();
    t_pin_reset();
    test_done();
  end
endmodule : test_ddr3_command_cke_decoder
`default_nettype wire
